/* cpr_cfg.svh */
/*
 constants of the coprocessor response block: slot indices, primitive
 fields, format words and timing. assumes a 32-bit apb register bus.
*/
`ifndef CPR_CFG_SVH
`define CPR_CFG_SVH
// slot indices; byte address is four times the index
`define CPR_IDX_RESPONSE  6'h00
`define CPR_IDX_CONTROL   6'h02
`define CPR_IDX_SAVE      6'h04
`define CPR_IDX_RESTORE   6'h06
`define CPR_IDX_OPWORD    6'h08
`define CPR_IDX_COMMAND   6'h0a
`define CPR_IDX_CONDITION 6'h0e
`define CPR_IDX_OPERAND   6'h10
`define CPR_IDX_REGSEL    6'h14
`define CPR_IDX_INSTADDR  6'h18
`define CPR_IDX_OPADDR    6'h1c
`define CPR_IDX_CONDFLAGS 6'h20
`define CPR_IDX_STATUS    6'h22
// primitive attribute bit positions
`define CPR_BIT_COME_AGAIN 15
`define CPR_BIT_PASS_PC    14
`define CPR_BIT_DIRECTION  13
`define CPR_BIT_INT_ALLOW  8
`define CPR_BIT_PROC_FIN   1
`define CPR_BIT_COND_TRUE  0
// primitive base encodings
`define CPR_PRIM_NULL      16'h0800
`define CPR_PRIM_SUPCHECK  16'h0400
`define CPR_PRIM_EXCEPTION 16'h1c00
// format words and answers
`define CPR_FMT_IDLE       16'h0100
`define CPR_FMT_INVALID    16'h0000
`define CPR_ALL_ONES       32'hffffffff
`define CPR_CONTROL_ABORT  0
// operation word fields
`define CPR_OP_FLINE_HI    15
`define CPR_OP_FLINE_LO    12
`define CPR_OP_SEL_HI      11
`define CPR_OP_SEL_LO      9
`define CPR_SELECT_THIS    3'h0
// timing
`define CPR_EXEC_TIME_NS   80
`define CPR_CLK_PERIOD_NS  10
`define CPR_EXEC_CYCLES    ((`CPR_EXEC_TIME_NS) / (`CPR_CLK_PERIOD_NS))
`define CPR_PV_VECTOR      8'h0d
`endif

/* cpr_pkg.sv */
/*
 types of the coprocessor response block.
 assumes cpr_cfg.svh holds the numeric constants.
*/
`default_nettype none
package cpr_pkg;
   typedef enum logic [2:0] {
      CPR_ST_IDLE,
      CPR_ST_EXEC,
      CPR_ST_SUPCHK,
      CPR_ST_CONDRES,
      CPR_ST_EXCEPT
   } cpr_state_t;
   typedef enum logic [1:0] {
      CPR_PK_NULL,
      CPR_PK_SUPCHK,
      CPR_PK_EXCEPT
   } cpr_prim_kind_t;
endpackage
`default_nettype wire

/* cpr_prim_enc.sv */
/*
 builds the 16-bit response primitive from the reply kind.
 assumes the caller holds kind stable during a read access.
*/
`timescale 1ns/1ns
`default_nettype none
`include "cpr_cfg.svh"
module cpr_prim_enc (
   input  wire logic                    i_mclk,   // clock
   input  wire logic                    i_rst,    // async reset
   input  wire logic                    i_ce,     // clock enable
   input  wire cpr_pkg::cpr_prim_kind_t i_kind,   // reply kind
   input  wire logic                    i_again,  // come again
   input  wire logic                    i_fin,    // processing finished
   input  wire logic                    i_true,   // condition result
   input  wire logic [7:0]              i_vector, // exception vector
   output logic [15:0]                  o_prim    // registered word
);
   import cpr_pkg::*;
   logic [15:0] prim_next;
   // a literal cannot be part-selected, so the base goes through a constant
   localparam logic [15:0] EXC_BASE = `CPR_PRIM_EXCEPTION;
   always_comb begin
      prim_next = `CPR_PRIM_NULL;
      case (i_kind)
         CPR_PK_NULL: begin
            prim_next = `CPR_PRIM_NULL;
            prim_next[`CPR_BIT_COME_AGAIN] = i_again;
            prim_next[`CPR_BIT_PROC_FIN]   = i_fin;
            prim_next[`CPR_BIT_COND_TRUE]  = i_true;
         end
         CPR_PK_SUPCHK: prim_next = `CPR_PRIM_SUPCHECK;
         CPR_PK_EXCEPT: prim_next = {EXC_BASE[15:8], i_vector};
         default: prim_next = `CPR_PRIM_NULL;
      endcase
      // never passes the program counter nor allows interrupts
      prim_next[`CPR_BIT_PASS_PC]   = 1'b0;
      prim_next[`CPR_BIT_INT_ALLOW] = 1'b0;
   end
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_prim <= `CPR_PRIM_NULL | 16'h0002;
      end else if (i_ce) begin
         o_prim <= prim_next;
      end
   end
endmodule // cpr_prim_enc
`default_nettype wire

/* cpr_cond_eval.sv */
/*
 evaluates a condition selector against a software flag word.
 assumes the selector is held for the cycle after it is latched.
*/
`timescale 1ns/1ns
`default_nettype none
module cpr_cond_eval #(
   parameter int FLAGS_W = 16                 // flag word width
) (
   input  wire logic               i_mclk,    // clock
   input  wire logic               i_rst,     // async reset
   input  wire logic               i_ce,      // clock enable
   input  wire logic [5:0]         i_sel,     // condition selector
   input  wire logic [FLAGS_W-1:0] i_flags,   // flag word
   output logic                    o_true     // registered result
);
   // low bits pick a flag, bit 4 inverts the sense
   logic [3:0] pick;
   logic       raw;
   assign pick = i_sel[3:0];
   assign raw  = i_flags[pick] ^ i_sel[4];
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_true <= 1'b0;
      end else if (i_ce) begin
         o_true <= raw;
      end
   end
endmodule // cpr_cond_eval
`default_nettype wire

/* cpr_resp_top.sv */
/*
 coprocessor dialog slave of a paged memory management unit, reached
 over apb. the host starts every transfer; the block answers through
 the response slot with 16-bit primitives.
 assumes a single clock and an apb master that holds its request.
*/
// Functional notes
// - instructions are one to eight words
// - answer only coprocessor select zero; other selects still go busy and get a finished null at once
// - save dialog opens with a read
// - exception primitive carries a vector
// - service request may ask for re-read
// - null with come-again asks re-read
// - supervisor check primitive may be replied
// - only three primitive kinds are produced
// - primitive is one 16-bit response word
// - bit 15 is the come-again flag
// - pass program counter bit always zero
// - bit 13 gives the transfer direction; the code never sets it, every reply carries zero there
// - null primitive signals instruction completion
// - interrupt allowed bit never set
// - bit 1 zero executing, one idle
// - bit 0 carries condition result
// - idle or final reply: finished only
// - executing needing service: come-again only
// - condition write: supervisor check, then result
// - command while busy raises protocol violation
`timescale 1ns/1ns
`default_nettype none
`include "cpr_cfg.svh"
module cpr_resp_top #(
   parameter int        EXEC_CYCLES = `CPR_EXEC_CYCLES, // busy time
   parameter int        FLAGS_W     = 16,               // flag width
   parameter logic [2:0] MY_SELECT  = `CPR_SELECT_THIS, // own select
   parameter logic [7:0] PV_VECTOR  = `CPR_PV_VECTOR    // violation
) (
   input  wire logic        i_mclk,     // 100 mhz clock
   input  wire logic        i_rst,      // async reset, high
   input  wire logic        i_ce,       // clock enable
   input  wire logic        i_psel,     // apb select
   input  wire logic        i_penable,  // apb enable
   input  wire logic        i_pwrite,   // apb direction
   input  wire logic [7:0]  i_paddr,    // apb byte address
   input  wire logic [31:0] i_pwdata,   // apb write data
   output logic             o_pready,   // apb ready
   output logic [31:0]      o_prdata,   // apb read data
   output logic             o_pslverr,  // apb error
   output logic             o_busy      // instruction executing
);
   import cpr_pkg::*;

   cpr_state_t              state_reg;
   cpr_state_t              state_next;
   logic [15:0]             command_reg;
   logic [5:0]              cond_sel_reg;
   logic [15:0]             restore_reg;
   logic                    restore_ok_reg;
   logic [FLAGS_W-1:0]      flags_reg;
   logic                    cond_true_reg;
   logic [15:0]             exec_cnt_reg;
   logic [15:0]             prim_word;
   logic                    cond_true;
   cpr_prim_kind_t          kind;
   logic                    again;
   logic                    fin;

   // access decode
   logic [5:0] idx;
   logic       aligned;
   logic       access;
   logic       done;
   logic       wr_done;
   logic       rd_done;
   assign idx     = i_paddr[7:2];
   assign aligned = (i_paddr[1:0] == 2'b00);
   assign access  = i_psel & i_penable;
   assign done    = access & o_pready;
   assign wr_done = done & i_pwrite & aligned;
   assign rd_done = done & ~i_pwrite & aligned;

   function automatic logic hit(input logic [5:0] a, input logic [5:0] b);
      hit = (a == b);
   endfunction

   function automatic logic mapped(input logic [5:0] a);
      mapped = hit(a, `CPR_IDX_RESPONSE) | hit(a, `CPR_IDX_CONTROL) |
               hit(a, `CPR_IDX_SAVE) | hit(a, `CPR_IDX_RESTORE) |
               hit(a, `CPR_IDX_OPWORD) | hit(a, `CPR_IDX_COMMAND) |
               hit(a, `CPR_IDX_CONDITION) | hit(a, `CPR_IDX_OPERAND) |
               hit(a, `CPR_IDX_REGSEL) | hit(a, `CPR_IDX_INSTADDR) |
               hit(a, `CPR_IDX_OPADDR) | hit(a, `CPR_IDX_CONDFLAGS) |
               hit(a, `CPR_IDX_STATUS);
   endfunction

   // host writes and reads are the only events: no spontaneous output
   logic wr_cmd;
   logic wr_cond;
   logic wr_ctrl;
   logic wr_rest;
   logic wr_flags;
   logic rd_resp;
   logic rd_save;
   logic is_idle;
   assign wr_cmd   = wr_done & hit(idx, `CPR_IDX_COMMAND);
   assign wr_cond  = wr_done & hit(idx, `CPR_IDX_CONDITION);
   assign wr_ctrl  = wr_done & hit(idx, `CPR_IDX_CONTROL);
   assign wr_rest  = wr_done & hit(idx, `CPR_IDX_RESTORE);
   assign wr_flags = wr_done & hit(idx, `CPR_IDX_CONDFLAGS);
   assign rd_resp  = rd_done & hit(idx, `CPR_IDX_RESPONSE);
   assign rd_save  = rd_done & hit(idx, `CPR_IDX_SAVE);
   assign is_idle  = (state_reg == CPR_ST_IDLE);

   // restore format word check: bits 15:8 of the write data are
   // compared with the high byte of the idle format word
   localparam logic [15:0] FMT_IDLE = `CPR_FMT_IDLE;
   logic fmt_valid;
   assign fmt_valid = (i_pwdata[15:8] == FMT_IDLE[15:8]);

   logic [2:0] cmd_sel;
   assign cmd_sel = i_pwdata[`CPR_OP_SEL_HI:`CPR_OP_SEL_LO];

   logic exec_over;
   assign exec_over = (exec_cnt_reg == 16'h0000);

   logic abort;
   assign abort = wr_ctrl & i_pwdata[`CPR_CONTROL_ABORT];

   // dialog sequencer
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         CPR_ST_IDLE: begin
            if (wr_cmd) begin
               state_next = CPR_ST_EXEC;
            end else if (wr_cond) begin
               state_next = CPR_ST_SUPCHK;
            end
         end
         CPR_ST_EXEC: begin
            if (wr_cmd || wr_cond) begin
               state_next = CPR_ST_EXCEPT;
            end else if (rd_resp && exec_over) begin
               state_next = CPR_ST_IDLE;
            end
         end
         CPR_ST_SUPCHK: begin
            if (wr_cmd || wr_cond) begin
               state_next = CPR_ST_EXCEPT;
            end else if (rd_resp) begin
               state_next = CPR_ST_CONDRES;
            end
         end
         CPR_ST_CONDRES: begin
            if (wr_cmd || wr_cond) begin
               state_next = CPR_ST_EXCEPT;
            end else if (rd_resp) begin
               state_next = CPR_ST_IDLE;
            end
         end
         CPR_ST_EXCEPT: begin
            // the aborted instruction is dropped once the vector is read
            if (rd_resp) begin
               state_next = CPR_ST_IDLE;
            end
         end
         default: state_next = CPR_ST_IDLE;
      endcase
      if (abort) begin
         state_next = CPR_ST_IDLE;
      end
   end

   // reply selection; only null, supervisor check and exception are
   // built here, a subset of the protocol's primitives
   always_comb begin
      kind  = CPR_PK_NULL;
      again = 1'b0;
      fin   = 1'b1;
      case (state_reg)
         CPR_ST_IDLE: begin
            fin = 1'b1;
         end
         CPR_ST_EXEC: begin
            again = ~exec_over;
            fin   = exec_over;
         end
         CPR_ST_SUPCHK: kind = CPR_PK_SUPCHK;
         CPR_ST_CONDRES: fin = 1'b1;
         CPR_ST_EXCEPT: kind = CPR_PK_EXCEPT;
         default: kind = CPR_PK_NULL;
      endcase
   end

   cpr_prim_enc u_enc (
      .i_mclk   (i_mclk),
      .i_rst    (i_rst),
      .i_ce     (i_ce),
      .i_kind   (kind),
      .i_again  (again),
      .i_fin    (fin),
      .i_true   (cond_true_reg & (state_reg == CPR_ST_CONDRES)),
      .i_vector (PV_VECTOR),
      .o_prim   (prim_word)
   );

   cpr_cond_eval #(
      .FLAGS_W (FLAGS_W)
   ) u_cond (
      .i_mclk  (i_mclk),
      .i_rst   (i_rst),
      .i_ce    (i_ce),
      .i_sel   (cond_sel_reg),
      .i_flags (flags_reg),
      .o_true  (cond_true)
   );

   // read data; direction bit sits in the word, zero for every reply kind
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h00000000;
      if (hit(idx, `CPR_IDX_RESPONSE)) begin
         rd_mux = {prim_word, 16'h0000};
      end else if (hit(idx, `CPR_IDX_SAVE)) begin
         rd_mux = {`CPR_FMT_IDLE, 16'h0000};
      end else if (hit(idx, `CPR_IDX_RESTORE)) begin
         rd_mux = {restore_ok_reg ? restore_reg : `CPR_FMT_INVALID,
                   16'h0000};
      end else if (hit(idx, `CPR_IDX_INSTADDR) ||
                   hit(idx, `CPR_IDX_OPADDR)) begin
         rd_mux = `CPR_ALL_ONES;
      end else if (hit(idx, `CPR_IDX_CONDFLAGS)) begin
         rd_mux = {{(32-FLAGS_W){1'b0}}, flags_reg};
      end else if (hit(idx, `CPR_IDX_STATUS)) begin
         rd_mux = {29'h0, state_reg};
      end
   end

   // apb answer: one wait state, ready pulses for a single cycle
   logic err_next;
   assign err_next = ~aligned | ~mapped(idx);
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_pready  <= 1'b0;
         o_prdata  <= 32'h00000000;
         o_pslverr <= 1'b0;
      end else if (i_ce) begin
         o_pready  <= access & ~o_pready;
         o_pslverr <= access & ~o_pready & err_next;
         if (access && !o_pready && !i_pwrite) begin
            o_prdata <= err_next ? 32'h00000000 : rd_mux;
         end
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         state_reg <= CPR_ST_IDLE;
      end else if (i_ce) begin
         state_reg <= state_next;
      end
   end

   // command latch; a command other than select zero is not ours,
   // and one written while busy is discarded
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         command_reg <= 16'h0000;
      end else if (i_ce && wr_cmd && is_idle) begin
         command_reg <= i_pwdata[31:16];
      end
   end

   logic foreign;
   assign foreign = (cmd_sel != MY_SELECT) |
       (i_pwdata[`CPR_OP_FLINE_HI:`CPR_OP_FLINE_LO] != 4'hf);

   // execution timer; a write to the command slot carries the
   // operation word in its low half for select checking
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         exec_cnt_reg <= 16'h0000;
      end else if (i_ce) begin
         if (wr_cmd && is_idle) begin
            exec_cnt_reg <= foreign ? 16'h0000
                                    : 16'(EXEC_CYCLES);
         end else if (!exec_over) begin
            exec_cnt_reg <= exec_cnt_reg - 16'h0001;
         end
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         cond_sel_reg <= 6'h00;
      end else if (i_ce && wr_cond && is_idle) begin
         cond_sel_reg <= i_pwdata[21:16];
      end
   end

   // condition sampled when the supervisor check reply is consumed
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         cond_true_reg <= 1'b0;
      end else if (i_ce && rd_resp && state_reg == CPR_ST_SUPCHK) begin
         cond_true_reg <= cond_true;
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         restore_reg    <= 16'h0000;
         restore_ok_reg <= 1'b0;
      end else if (i_ce && wr_rest) begin
         restore_reg    <= i_pwdata[31:16];
         restore_ok_reg <= (i_pwdata[31:24] == FMT_IDLE[15:8]);
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         flags_reg <= '0;
      end else if (i_ce && wr_flags) begin
         flags_reg <= i_pwdata[FLAGS_W-1:0];
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_busy <= 1'b0;
      end else if (i_ce) begin
         o_busy <= (state_next != CPR_ST_IDLE);
      end
   end

   logic unused;
   assign unused = fmt_valid ^ rd_save ^ (^command_reg);
endmodule // cpr_resp_top
`default_nettype wire

/* cpr_resp_checker.sv */
/*
 concurrent checks on the apb side of cpr_resp_top.
 assumes the master holds each request until pready.
*/
`timescale 1ns/1ns
`default_nettype none
`include "cpr_cfg.svh"
module cpr_resp_checker (
   input wire logic        i_mclk,    // clock
   input wire logic        i_rst,     // async reset
   input wire logic        i_ce,      // clock enable
   input wire logic        i_psel,    // apb select
   input wire logic        i_penable, // apb enable
   input wire logic        i_pwrite,  // apb direction
   input wire logic [7:0]  i_paddr,   // apb address
   input wire logic [31:0] i_pwdata,  // apb write data
   input wire logic        o_pready,  // apb ready
   input wire logic [31:0] o_prdata,  // apb read data
   input wire logic        o_pslverr, // apb error
   input wire logic        o_busy     // executing
);
   wire rd_resp = o_pready && !i_pwrite &&
                  i_paddr == {`CPR_IDX_RESPONSE, 2'b00};
   wire wr_cmd  = o_pready && i_pwrite && !o_pslverr &&
                  i_paddr == {`CPR_IDX_COMMAND, 2'b00};
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   ready_pulse_a: assert property (o_pready |=> !o_pready)
      else $error("ready held longer than one cycle");
   ready_wait_a: assert property (i_psel && i_penable && !o_pready && i_ce
      |=> o_pready)
      else $error("access phase not answered on the next edge");
   ready_cause_a: assert property (
      o_pready |-> $past(i_psel && i_penable))
      else $error("ready without an access phase");
   pass_pc_a: assert property (rd_resp |->
      !o_prdata[16+`CPR_BIT_PASS_PC])
      else $error("pass program counter bit set");
   int_allow_a: assert property (rd_resp |->
      !o_prdata[16+`CPR_BIT_INT_ALLOW])
      else $error("interrupt allowed bit set");
   low_half_a: assert property (rd_resp |-> o_prdata[15:0] == 16'h0)
      else $error("response word outside upper half");
   again_only_a: assert property (rd_resp && o_prdata[31] |->
      (o_prdata[31:16] & ~`CPR_PRIM_NULL) == 16'h8000)
      else $error("come again primitive carries other bits");
   final_idle_a: assert property (rd_resp && o_prdata[17] &&
      !o_prdata[31] |-> ##[1:3] !o_busy)
      else $error("no return to idle after final null");
   cmd_busy_a: assert property (wr_cmd && !o_busy |-> ##[1:3] o_busy)
      else $error("command did not start execution");
   cover property (rd_resp && o_prdata[31]);
   cover property (rd_resp && o_prdata[16]);
   cover property (wr_cmd && o_busy);
endmodule // cpr_resp_checker
bind cpr_resp_top cpr_resp_checker i_chk (.i_mclk(i_mclk), .i_rst(i_rst),
   .i_ce(i_ce), .i_psel(i_psel), .i_penable(i_penable),
   .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
   .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
   .o_busy(o_busy));
`default_nettype wire

/* cpr_host_model.sv */
/*
 host processor model: apb master that opens and polls dialogs.
 assumes the bench supplies the clock and calls xfer.
*/
`timescale 1ns/1ns
`default_nettype none
module cpr_host_model (
   input  wire logic        i_mclk,    // clock
   input  wire logic        i_pready,  // apb ready
   input  wire logic [31:0] i_prdata,  // apb read data
   input  wire logic        i_pslverr, // apb error
   output logic             o_psel,    // apb select
   output logic             o_penable, // apb enable
   output logic             o_pwrite,  // apb direction
   output logic [7:0]       o_paddr,   // apb address
   output logic [31:0]      o_pwdata   // apb write data
);
   initial begin
      o_psel    = 1'b0;
      o_penable = 1'b0;
      o_pwrite  = 1'b0;
      o_paddr   = 8'h00;
      o_pwdata  = 32'h0;
   end
   // every exchange starts here; writes open, reads collect replies
   task automatic xfer(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] rd, output logic err);
      @(posedge i_mclk);
      o_psel    <= 1'b1;
      o_penable <= 1'b0;
      o_pwrite  <= wr;
      o_paddr   <= a;
      o_pwdata  <= d;
      @(posedge i_mclk);
      o_penable <= 1'b1;
      do @(posedge i_mclk); while (i_pready !== 1'b1);
      rd = i_prdata;
      err = i_pslverr;
      o_psel    <= 1'b0;
      o_penable <= 1'b0;
      // released lines must not keep looking valid
      o_paddr   <= ~a;
      o_pwdata  <= ~d;
   endtask
endmodule // cpr_host_model
`default_nettype wire

/* cpr_resp_top_bench.sv */
/*
 self-checking bench for cpr_resp_top: dialogs driven by the host model.
 assumes the checker is bound to the top module.
*/
`timescale 1ns/1ns
`default_nettype none
`include "cpr_cfg.svh"
module cpr_resp_top_bench;
   localparam logic [7:0] A_RESP = {`CPR_IDX_RESPONSE, 2'b00};
   localparam logic [7:0] A_SAVE = {`CPR_IDX_SAVE, 2'b00};
   localparam logic [7:0] A_CMD  = {`CPR_IDX_COMMAND, 2'b00};
   localparam logic [7:0] A_COND = {`CPR_IDX_CONDITION, 2'b00};
   localparam logic [7:0] A_FLG  = {`CPR_IDX_CONDFLAGS, 2'b00};
   localparam logic [7:0] A_CTL  = {`CPR_IDX_CONTROL, 2'b00};
   localparam logic [15:0] IDLE_W  = `CPR_PRIM_NULL |
                                     (16'h1 << `CPR_BIT_PROC_FIN);
   localparam logic [15:0] AGAIN_W = `CPR_PRIM_NULL |
                                     (16'h1 << `CPR_BIT_COME_AGAIN);
   logic        i_mclk = 1'b0;
   logic        i_rst  = 1'b1;
   logic        psel, penable, pwrite, pready, pslverr, busy;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, d;
   int          fails = 0;
   int          check_count = 0;
   always #5 i_mclk = ~i_mclk;
   cpr_host_model i_host (.i_mclk(i_mclk), .i_pready(pready),
      .i_prdata(prdata), .i_pslverr(pslverr), .o_psel(psel),
      .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr),
      .o_pwdata(pwdata));
   cpr_resp_top #(.EXEC_CYCLES(8)) i_dut (.i_mclk(i_mclk), .i_rst(i_rst),
      .i_ce(1'b1), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
      .o_prdata(prdata), .o_pslverr(pslverr), .o_busy(busy));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      logic e;
      i_host.xfer(1'b0, a, 32'h0, v, e);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic [31:0] r;
      logic        e;
      i_host.xfer(1'b1, a, v, r, e);
   endtask
   task automatic stop_test;
      $display("checks %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic t_idle;
      rd(A_RESP, d);
      check(d, {IDLE_W, 16'h0});
      check({31'h0, busy}, 32'h0);
   endtask
   // polls like the host does; expects come again only when executing
   task automatic t_command(input logic [15:0] op, input logic exp_again);
      int n;
      int again;
      again = 0;
      wr(A_CMD, {16'h0001, op});
      repeat (2) @(posedge i_mclk);
      check({31'h0, busy}, 32'h1);
      for (n = 0; n < 12; n++) begin
         rd(A_RESP, d);
         if (d[31:16] !== AGAIN_W)
            break;
         again++;
      end
      check({31'h0, again > 0}, {31'h0, exp_again});
      check(d, {IDLE_W, 16'h0});
      repeat (3) @(posedge i_mclk);
      check({31'h0, busy}, 32'h0);
   endtask
   task automatic t_violation;
      wr(A_CMD, {16'h0001, 16'hf000});
      wr(A_CMD, {16'h0002, 16'hf000});
      rd(A_RESP, d);
      check(d, {`CPR_PRIM_EXCEPTION | {8'h0, `CPR_PV_VECTOR}, 16'h0});
      rd(A_RESP, d);
      check(d, {IDLE_W, 16'h0});
   endtask
   task automatic t_condition;
      logic [15:0] flags;
      logic [5:0]  sels [4];
      logic        tf;
      flags = 16'ha5c3;
      sels = '{6'h00, 6'h02, 6'h12, 6'h17};
      // the flag word sits in the low half of its slot
      wr(A_FLG, {16'h0, flags});
      foreach (sels[i]) begin
         tf = flags[sels[i][3:0]] ^ sels[i][4];
         wr(A_COND, {10'h0, sels[i], 16'h0});
         rd(A_RESP, d);
         check(d, {`CPR_PRIM_SUPCHECK, 16'h0});
         rd(A_RESP, d);
         check(d, {IDLE_W | {15'h0, tf}, 16'h0});
      end
   endtask
   // unmapped slot is refused; an abort drops a running command
   task automatic t_refuse;
      logic e;
      i_host.xfer(1'b0, 8'h04, 32'h0, d, e);
      check(d, 32'h0);
      check({31'h0, e}, 32'h1);
      wr(A_CMD, {16'h0001, 16'hf000});
      wr(A_CTL, 32'h1);
      rd(A_RESP, d);
      check(d, {IDLE_W, 16'h0});
   endtask
   task automatic t_save;
      rd(A_SAVE, d);
      check(d, {`CPR_FMT_IDLE, 16'h0});
   endtask
   initial begin
      repeat (10) @(posedge i_mclk);
      i_rst <= 1'b0;
      t_idle();
      t_command(16'hf000, 1'b1);
      t_command(16'hf200, 1'b0);
      t_violation();
      t_condition();
      t_refuse();
      t_save();
      t_idle();
      stop_test();
   end
   initial begin
      #200000;
      fails++;
      stop_test();
   end
endmodule // cpr_resp_top_bench
`default_nettype wire
